/* File: rtl/ddio_pkg.sv */
// ddio_pkg: port selectors, operation codes and reset values for the display i/o ports
// assumes a single cycle clock domain and a cpu-side port command interface
package ddio_pkg;

  // port selector codes
  localparam logic [3:0] PORT_WAKE   = 4'h0; // wake-capable input port
  localparam logic [3:0] PORT_PLAIN  = 4'h1; // plain input port
  localparam logic [3:0] PORT_BIDIR1 = 4'h2; // first bidirectional port
  localparam logic [3:0] PORT_BIDIR2 = 4'h3; // second bidirectional port
  localparam logic [3:0] PORT_DIG1   = 4'h4; // first digit drive port
  localparam logic [3:0] PORT_DIG2   = 4'h5; // second digit drive port
  localparam logic [3:0] PORT_SEG1   = 4'h6; // first segment drive port
  localparam logic [3:0] PORT_SEG2   = 4'h7; // second segment drive port
  localparam logic [3:0] PORT_NDIG   = 4'h8; // narrow digit drive port
  localparam logic [3:0] PORT_HOLD   = 4'h9; // standby request pin as input bit

  // operation codes
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000, // idle
    OP_READ  = 3'b001, // nibble read
    OP_WRITE = 3'b010, // nibble write to latch
    OP_SET   = 3'b011, // set one latch bit
    OP_CLR   = 3'b100, // clear one latch bit
    OP_TEST  = 3'b101  // test one bit for branch
  } ddio_op_t;

  // latch reset values: all outputs off
  localparam logic [3:0] LATCH_RESET = 4'h0;
  localparam logic [3:0] NARROW_MASK = 4'h3; // narrow port has two bits

endpackage : ddio_pkg

/* File: rtl/ddio_ports.sv */
// ddio_ports: parallel port logic of the display driver microcomputer
// assumes the cpu issues one port operation per clock and pins are synchronous to clk_sys
//
// Notes on behaviour
// (R1) input ports: nibble read, single-bit test
// (R2) bidir ports as input: read, test
// (R3) bidir ports output: write, set, clear
// (R4) high-voltage ports: write, set, clear latch
// (R5) high-voltage reads return latch, not pins
// (R6) high-voltage latch bit testable for branch
// (R7) narrow port: two-bit write, set, clear
// (R8) narrow port: latch readback and bit test
// (R9) wake input port releases instruction standby
// (R10) standby request pin readable as input bit
// (R11) ten digit bits: two nibbles, two-bit
// (R12) eight segment bits: two nibbles
// (R13) bit set/clear touches only addressed bit
`timescale 1ns/1ps

module ddio_ports (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // cpu port command
  input  wire ddio_pkg::ddio_op_t opCode,
  input  wire logic [3:0]         opPort,
  input  wire logic [1:0]         opBit,
  input  wire logic [3:0]         opData,
  output logic      [3:0]         rdData,
  output logic                    testFlag,
  // bidirectional port direction, one bit per port, 1 = output
  input  wire logic [1:0]         bidirOut,
  // standby control
  input  wire logic               haltActive,
  output logic                    haltRelease,
  // input pins
  input  wire logic [3:0]         wakeCapableInputPort,
  input  wire logic [3:0]         plainInputPort,
  input  wire logic               holdPin,
  // bidirectional pins
  input  wire logic [3:0]         firstBidirIn,
  output logic      [3:0]         firstBidirOut,
  output logic      [3:0]         firstBidirOe,
  input  wire logic [3:0]         secondBidirIn,
  output logic      [3:0]         secondBidirOut,
  output logic      [3:0]         secondBidirOe,
  // high-voltage outputs
  output logic      [3:0]         firstDigitDrivePort,
  output logic      [3:0]         secondDigitDrivePort,
  output logic      [3:0]         firstSegmentDrivePort,
  output logic      [3:0]         secondSegmentDrivePort,
  output logic      [1:0]         narrowDigitDrivePort
);

  // output latches, index 0..1 bidir, 2..6 high-voltage ports
  // the narrow port shares the array; its top two latch bits are held at zero
  logic [3:0] latchReg [0:6];
  logic [3:0] latchNext [0:6];
  logic [1:0] dirReg;        // registered direction for pin enables
  logic [3:0] rdDataReg;     // read result
  logic       testFlagReg;   // branch condition result
  logic       haltRelReg;    // wake request

  // decode: selected latch index and whether the port owns a latch
  logic [2:0] latchIdx;
  logic       hasLatch;
  assign hasLatch = (opPort >= ddio_pkg::PORT_BIDIR1) && (opPort <= ddio_pkg::PORT_NDIG);
  assign latchIdx = hasLatch ? 3'(opPort - ddio_pkg::PORT_BIDIR1) : 3'd0;

  // bidir ports accept latch writes only while set as output
  wire bidirSel  = (opPort == ddio_pkg::PORT_BIDIR1) || (opPort == ddio_pkg::PORT_BIDIR2);
  wire bidirIsOut = bidirSel ? bidirOut[opPort[0]] : 1'b1;
  wire writeEn   = hasLatch && bidirIsOut;
  wire isNarrow  = (opPort == ddio_pkg::PORT_NDIG);

  // narrow port keeps only two bits; higher bits of its latch stay zero
  wire [3:0] portMask = isNarrow ? ddio_pkg::NARROW_MASK : 4'hF;
  wire [3:0] bitOne   = 4'(1) << opBit;
  wire [3:0] curLatch = latchReg[latchIdx];

  // read source: pins for inputs and bidir inputs, latch for output ports
  // a bidir port in output mode reads back its own latch, so software doing a
  // read-modify-write never picks up a key that happens to pull the pin
  logic [3:0] readVal;
  always_comb begin
    unique case (opPort)
      ddio_pkg::PORT_WAKE:   readVal = wakeCapableInputPort; // R1
      ddio_pkg::PORT_PLAIN:  readVal = plainInputPort;       // R1
      ddio_pkg::PORT_BIDIR1: readVal = bidirOut[0] ? latchReg[0] : firstBidirIn;  // R2
      ddio_pkg::PORT_BIDIR2: readVal = bidirOut[1] ? latchReg[1] : secondBidirIn; // R2
      ddio_pkg::PORT_HOLD:   readVal = {3'b000, holdPin};    // R10
      default:               readVal = hasLatch ? (curLatch & portMask) : 4'h0; // R5 R8
    endcase
  end

  // next latch values: only the addressed latch changes, and a set or clear changes only its addressed bit
  // bit ops work on the current latch in place, so a set or clear costs one
  // cycle like a nibble write and needs no mask register
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      latchNext[i] = latchReg[i];
    end
    if (writeEn) begin
      unique case (opCode)
        ddio_pkg::OP_WRITE: latchNext[latchIdx] = opData & portMask;               // R3 R4 R7
        ddio_pkg::OP_SET:   latchNext[latchIdx] = (curLatch | bitOne) & portMask;  // R13
        ddio_pkg::OP_CLR:   latchNext[latchIdx] = curLatch & ~bitOne;              // R13
        default:            latchNext[latchIdx] = curLatch;
      endcase
    end
  end

  // latch registers
  // reset is synchronous: digits and segments go dark at the first clk_sys edge that sees rst high
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 7; i++) begin
      latchReg[i] <= rst ? ddio_pkg::LATCH_RESET : latchNext[i];
    end
  end

  // read, test and wake results, registered so outputs come from flops
  // direction is registered too so pin enables come from a flop; the enable
  // therefore trails bidirOut by one cycle, while latch writes follow it at once
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdDataReg   <= 4'h0;
      testFlagReg <= 1'b0;
      haltRelReg  <= 1'b0;
      dirReg      <= 2'b00;
    end else begin
      dirReg <= bidirOut;
      rdDataReg <= (opCode == ddio_pkg::OP_READ) ? readVal : rdDataReg;
      // a test of a bit beyond the narrow port width reads as zero
      testFlagReg <= (opCode == ddio_pkg::OP_TEST) ? readVal[opBit] : testFlagReg; // R6 R8
      // wake is level sensitive: a key still held as standby is entered
      // releases it at once, which suits a key scan that polls after wake
      // any high wake pin releases the instruction standby
      haltRelReg <= haltActive && (|wakeCapableInputPort); // R9
    end
  end

  // pin drivers: ten digit bits and eight segment bits from latches
  // every pin output is a plain copy of a flop, no logic sits after it
  assign firstDigitDrivePort    = latchReg[2]; // R11
  assign secondDigitDrivePort   = latchReg[3]; // R11
  assign narrowDigitDrivePort   = latchReg[6][1:0]; // R11
  assign firstSegmentDrivePort  = latchReg[4]; // R12
  assign secondSegmentDrivePort = latchReg[5]; // R12
  assign firstBidirOut  = latchReg[0];
  assign secondBidirOut = latchReg[1];
  assign firstBidirOe   = {4{dirReg[0]}};
  assign secondBidirOe  = {4{dirReg[1]}};
  assign rdData      = rdDataReg;
  assign testFlag    = testFlagReg;
  assign haltRelease = haltRelReg;

  // checks below watch the pins one edge after an op is taken;
  // $past brings back the operands as they stood at that edge
  // latch bit operations
  // set changes only the addressed bit
  a_set_one_bit: assert property (@(posedge clk_sys) disable iff (rst) // R13
    (opCode == ddio_pkg::OP_SET && opPort == ddio_pkg::PORT_SEG1)
    |=> (firstSegmentDrivePort == ($past(firstSegmentDrivePort) | (4'(1) << $past(opBit)))))
    else $error("set altered other bits");

  // clear changes only the addressed bit
  a_clr_one_bit: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (opCode == ddio_pkg::OP_CLR && opPort == ddio_pkg::PORT_DIG1)
    |=> (firstDigitDrivePort == ($past(firstDigitDrivePort) & ~(4'(1) << $past(opBit)))))
    else $error("clear altered other bits");

  // nibble write lands on the digit port
  a_write_digit: assert property (@(posedge clk_sys) disable iff (rst) // R11
    (opCode == ddio_pkg::OP_WRITE && opPort == ddio_pkg::PORT_DIG2)
    |=> secondDigitDrivePort == $past(opData))
    else $error("digit write lost");

  // output port read returns latch
  a_read_latch: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (opCode == ddio_pkg::OP_READ && opPort == ddio_pkg::PORT_SEG2)
    |=> rdData == $past(secondSegmentDrivePort))
    else $error("readback not latch");

  // input port read returns pins
  a_read_input: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (opCode == ddio_pkg::OP_READ && opPort == ddio_pkg::PORT_PLAIN)
    |=> rdData == $past(plainInputPort))
    else $error("input read wrong");

  // bidir input read returns pins
  a_bidir_in: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (opCode == ddio_pkg::OP_READ && opPort == ddio_pkg::PORT_BIDIR1 && !bidirOut[0])
    |=> rdData == $past(firstBidirIn))
    else $error("bidir input read wrong");

  // bidir write when output reaches the pins
  a_bidir_out: assert property (@(posedge clk_sys) disable iff (rst) // R3
    (opCode == ddio_pkg::OP_WRITE && opPort == ddio_pkg::PORT_BIDIR2 && bidirOut[1])
    |=> secondBidirOut == $past(opData))
    else $error("bidir write lost");

  // narrow port keeps two bits
  a_narrow_write: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (opCode == ddio_pkg::OP_WRITE && opPort == ddio_pkg::PORT_NDIG)
    |=> narrowDigitDrivePort == $past(opData[1:0]))
    else $error("narrow write wrong");

  // test of narrow latch bit
  a_narrow_test: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (opCode == ddio_pkg::OP_TEST && opPort == ddio_pkg::PORT_NDIG && opBit == 2'd1)
    |=> testFlag == $past(narrowDigitDrivePort[1]))
    else $error("narrow test wrong");

  // test of segment latch bit
  a_seg_test: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (opCode == ddio_pkg::OP_TEST && opPort == ddio_pkg::PORT_SEG1)
    |=> testFlag == $past(firstSegmentDrivePort[opBit]))
    else $error("segment test wrong");

  // wake pins release standby one cycle later
  a_wake_release: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (haltActive && |wakeCapableInputPort) |=> haltRelease)
    else $error("wake not released");

  // hold pin read
  a_hold_read: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (opCode == ddio_pkg::OP_READ && opPort == ddio_pkg::PORT_HOLD)
    |=> rdData == {3'b000, $past(holdPin)})
    else $error("hold read wrong");

  // segment port two written
  a_seg_write: assert property (@(posedge clk_sys) disable iff (rst) // R12
    (opCode == ddio_pkg::OP_WRITE && opPort == ddio_pkg::PORT_SEG2)
    |=> secondSegmentDrivePort == $past(opData))
    else $error("segment write lost");

  // writes to an input-only port leave the first bidir latch alone
  a_input_no_write: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (opCode == ddio_pkg::OP_WRITE && opPort == ddio_pkg::PORT_PLAIN)
    |=> firstBidirOut == $past(firstBidirOut))
    else $error("input port write reached a latch");

  // wake port read returns its pins
  a_wake_read: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (opCode == ddio_pkg::OP_READ && opPort == ddio_pkg::PORT_WAKE)
    |=> rdData == $past(wakeCapableInputPort))
    else $error("wake port read wrong");

  // plain input bit test follows the pin
  a_input_test: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (opCode == ddio_pkg::OP_TEST && opPort == ddio_pkg::PORT_PLAIN)
    |=> testFlag == $past(plainInputPort[opBit]))
    else $error("input bit test wrong");

  // second bidir port read as input returns pins
  a_bidir2_in: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (opCode == ddio_pkg::OP_READ && opPort == ddio_pkg::PORT_BIDIR2 && !bidirOut[1])
    |=> rdData == $past(secondBidirIn))
    else $error("second bidir input read wrong");

  // bidir port set as input refuses latch changes
  a_bidir_refuse: assert property (@(posedge clk_sys) disable iff (rst) // R3
    (opCode inside {ddio_pkg::OP_WRITE, ddio_pkg::OP_SET, ddio_pkg::OP_CLR}
     && opPort == ddio_pkg::PORT_BIDIR1 && !bidirOut[0])
    |=> firstBidirOut == $past(firstBidirOut))
    else $error("input-mode bidir latch changed");

  // pin enables trail the direction input by one edge
  a_oe_follow: assert property (@(posedge clk_sys) disable iff (rst) // R3
    1'b1
    |=> firstBidirOe == {4{$past(bidirOut[0])}} && secondBidirOe == {4{$past(bidirOut[1])}})
    else $error("pin enable wrong");

  // set on the second digit port latch
  a_dig2_set: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (opCode == ddio_pkg::OP_SET && opPort == ddio_pkg::PORT_DIG2)
    |=> secondDigitDrivePort == ($past(secondDigitDrivePort) | (4'(1) << $past(opBit))))
    else $error("digit set wrong");

  // digit port read returns the latch
  a_dig1_read: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (opCode == ddio_pkg::OP_READ && opPort == ddio_pkg::PORT_DIG1)
    |=> rdData == $past(firstDigitDrivePort))
    else $error("digit readback not latch");

  // digit latch bit test
  a_dig1_test: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (opCode == ddio_pkg::OP_TEST && opPort == ddio_pkg::PORT_DIG1)
    |=> testFlag == $past(firstDigitDrivePort[opBit]))
    else $error("digit test wrong");

  // narrow port ignores a set of bits it does not have
  a_narrow_high: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (opCode == ddio_pkg::OP_SET && opPort == ddio_pkg::PORT_NDIG && opBit[1])
    |=> narrowDigitDrivePort == $past(narrowDigitDrivePort))
    else $error("narrow high set changed latch");

  // no release while the cpu runs
  a_no_release: assert property (@(posedge clk_sys) disable iff (rst) // R9
    !haltActive
    |=> !haltRelease)
    else $error("release without standby");

  // first segment port written
  a_seg1_write: assert property (@(posedge clk_sys) disable iff (rst) // R12
    (opCode == ddio_pkg::OP_WRITE && opPort == ddio_pkg::PORT_SEG1)
    |=> firstSegmentDrivePort == $past(opData))
    else $error("first segment write lost");

endmodule : ddio_ports

/* File: test/ddio_key_model.sv */
// ddio_key_model: switches and key contacts on the far side of both bidirectional ports
// assumes the bench sets switch levels and the port drivers come straight from the ports
`timescale 1ns/1ps

module ddio_key_model (
  // switch levels chosen by the bench
  input  wire logic [3:0] key1,
  input  wire logic [3:0] key2,
  // port drivers and enables
  input  wire logic [3:0] drv1,
  input  wire logic [3:0] oe1,
  input  wire logic [3:0] drv2,
  input  wire logic [3:0] oe2,
  // resolved pin levels
  output logic      [3:0] pin1,
  output logic      [3:0] pin2
);
  // a driving port overrides the weak switch bit by bit
  assign pin1 = (drv1 & oe1) | (key1 & ~oe1);
  assign pin2 = (drv2 & oe2) | (key2 & ~oe2);
endmodule : ddio_key_model

/* File: test/test_display_driver_io_ports.sv */
// test_display_driver_io_ports: self-checking bench for the display i/o ports
// assumes one clock at 20 MHz and a synchronous active-high reset
`timescale 1ns/1ps

module test_display_driver_io_ports;
  // clock, reset, cpu command and pin stimulus
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  ddio_pkg::ddio_op_t opCode = ddio_pkg::OP_NONE;
  logic [3:0]         opPort = 4'h0, opData = 4'h0, wake = 4'h0, plain = 4'h0;
  logic [1:0]         opBit = 2'h0, bidirOut = 2'h0;
  logic               haltActive = 1'b0, holdPin = 1'b0, testFlag, haltRelease;
  logic [3:0]         key1 = 4'h0, key2 = 4'h0, rdData, o1, e1, o2, e2, p1, p2;
  logic [3:0]         hv [4];
  logic [1:0]         ndig;
  int                 fail_count = 0, comparisons = 0, cycles = 0;

  always #25 clk_sys = ~clk_sys;

  ddio_ports ddio_ports_inst (.clk_sys(clk_sys), .rst(rst), .opCode(opCode), .opPort(opPort),
    .opBit(opBit), .opData(opData), .rdData(rdData), .testFlag(testFlag),
    .bidirOut(bidirOut), .haltActive(haltActive), .haltRelease(haltRelease),
    .wakeCapableInputPort(wake), .plainInputPort(plain), .holdPin(holdPin),
    .firstBidirIn(p1), .firstBidirOut(o1), .firstBidirOe(e1), .secondBidirIn(p2),
    .secondBidirOut(o2), .secondBidirOe(e2), .firstDigitDrivePort(hv[0]),
    .secondDigitDrivePort(hv[1]), .firstSegmentDrivePort(hv[2]),
    .secondSegmentDrivePort(hv[3]), .narrowDigitDrivePort(ndig));

  ddio_key_model ddio_key_model_inst (.key1(key1), .key2(key2), .drv1(o1), .oe1(e1),
    .drv2(o2), .oe2(e2), .pin1(p1), .pin2(p2));

  // one operation: driven 1 ns after an edge, taken at the next edge
  task automatic op(input ddio_pkg::ddio_op_t c, input logic [3:0] p, input logic [1:0] b,
                    input logic [3:0] d);
    @(posedge clk_sys);
    #1;
    opCode = c;
    opPort = p;
    opBit = b;
    opData = d;
    @(posedge clk_sys);
    #1;
    opCode = ddio_pkg::OP_NONE;
  endtask : op

  // nibble compare
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: nibble got %h expected %h", $time, got, exp);
    end
  endtask : chk4

  // single-bit compare
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // input ports read as nibble and as single bits, hold pin read as nibble
  task automatic test_inputs;
    wake = 4'h9;
    plain = 4'h6;
    holdPin = 1'b1;
    op(ddio_pkg::OP_READ, ddio_pkg::PORT_WAKE, 2'h0, 4'h0);
    chk4(rdData, 4'h9);
    op(ddio_pkg::OP_READ, ddio_pkg::PORT_PLAIN, 2'h0, 4'h0);
    chk4(rdData, 4'h6);
    op(ddio_pkg::OP_TEST, ddio_pkg::PORT_PLAIN, 2'h2, 4'h0);
    chk1(testFlag, 1'b1);
    op(ddio_pkg::OP_TEST, ddio_pkg::PORT_WAKE, 2'h1, 4'h0);
    chk1(testFlag, 1'b0);
    op(ddio_pkg::OP_READ, ddio_pkg::PORT_HOLD, 2'h0, 4'h0);
    chk4(rdData, 4'h1);
    op(ddio_pkg::OP_WRITE, ddio_pkg::PORT_PLAIN, 2'h0, 4'hF);
    chk4(o1, 4'h0);
    $display("test_inputs done");
  endtask : test_inputs

  // bidir ports as inputs, then as outputs with bit set and clear
  task automatic test_bidir;
    key1 = 4'hA;
    key2 = 4'h3;
    op(ddio_pkg::OP_READ, ddio_pkg::PORT_BIDIR1, 2'h0, 4'h0);
    chk4(rdData, 4'hA);
    op(ddio_pkg::OP_TEST, ddio_pkg::PORT_BIDIR1, 2'h1, 4'h0);
    chk1(testFlag, 1'b1);
    op(ddio_pkg::OP_READ, ddio_pkg::PORT_BIDIR2, 2'h0, 4'h0);
    chk4(rdData, 4'h3);
    op(ddio_pkg::OP_WRITE, ddio_pkg::PORT_BIDIR1, 2'h0, 4'hF);
    chk4(o1, 4'h0);
    chk4(e1, 4'h0);
    bidirOut = 2'b11;
    op(ddio_pkg::OP_WRITE, ddio_pkg::PORT_BIDIR1, 2'h0, 4'h5);
    chk4(e1 & e2, 4'hF);
    op(ddio_pkg::OP_SET, ddio_pkg::PORT_BIDIR1, 2'h1, 4'h0);
    chk4(o1, 4'h7);
    op(ddio_pkg::OP_CLR, ddio_pkg::PORT_BIDIR1, 2'h0, 4'h0);
    chk4(p1, 4'h6);
    op(ddio_pkg::OP_WRITE, ddio_pkg::PORT_BIDIR2, 2'h0, 4'hC);
    op(ddio_pkg::OP_CLR, ddio_pkg::PORT_BIDIR2, 2'h3, 4'h0);
    chk4(p2, 4'h4);
    chk4(o2, 4'h4);
    $display("test_bidir done");
  endtask : test_bidir

  // four high-voltage nibble ports: write, set, clear, readback, bit test
  task automatic test_hv;
    for (int i = 0; i < 4; i++) begin
      op(ddio_pkg::OP_WRITE, 4'h4 + 4'(i), 2'h0, 4'hA);
      op(ddio_pkg::OP_SET, 4'h4 + 4'(i), 2'h0, 4'h0);
      op(ddio_pkg::OP_CLR, 4'h4 + 4'(i), 2'h3, 4'h0);
      chk4(hv[i], 4'h3);
      op(ddio_pkg::OP_READ, 4'h4 + 4'(i), 2'h0, 4'h0);
      chk4(rdData, 4'h3);
      op(ddio_pkg::OP_TEST, 4'h4 + 4'(i), 2'h1, 4'h0);
      chk1(testFlag, 1'b1);
    end
    $display("test_hv done");
  endtask : test_hv

  // two-bit digit port
  task automatic test_narrow;
    op(ddio_pkg::OP_WRITE, ddio_pkg::PORT_NDIG, 2'h0, 4'h2);
    op(ddio_pkg::OP_SET, ddio_pkg::PORT_NDIG, 2'h0, 4'h0);
    chk4({2'b00, ndig}, 4'h3);
    op(ddio_pkg::OP_CLR, ddio_pkg::PORT_NDIG, 2'h1, 4'h0);
    op(ddio_pkg::OP_READ, ddio_pkg::PORT_NDIG, 2'h0, 4'h0);
    chk4(rdData, 4'h1);
    op(ddio_pkg::OP_TEST, ddio_pkg::PORT_NDIG, 2'h0, 4'h0);
    chk1(testFlag, 1'b1);
    op(ddio_pkg::OP_TEST, ddio_pkg::PORT_NDIG, 2'h3, 4'h0);
    chk1(testFlag, 1'b0);
    op(ddio_pkg::OP_WRITE, ddio_pkg::PORT_NDIG, 2'h0, 4'hE);
    op(ddio_pkg::OP_SET, ddio_pkg::PORT_NDIG, 2'h2, 4'h0);
    chk4({2'b00, ndig}, 4'h2);
    op(ddio_pkg::OP_READ, ddio_pkg::PORT_NDIG, 2'h0, 4'h0);
    chk4(rdData, 4'h2);
    $display("test_narrow done");
  endtask : test_narrow

  // standby release from the wake-capable port
  task automatic test_halt;
    wake = 4'h4;
    haltActive = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk1(haltRelease, 1'b0);
    wake = 4'h0;
    haltActive = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk1(haltRelease, 1'b0);
    wake = 4'h4;
    repeat (2) @(posedge clk_sys);
    #1;
    chk1(haltRelease, 1'b1);
    $display("test_halt done");
  endtask : test_halt

  // reset in mid-run clears latches, results and pin enables
  task automatic test_reset;
    @(posedge clk_sys);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk4(hv[1], 4'h0);
    chk4(hv[3], 4'h0);
    chk4({2'b00, ndig}, 4'h0);
    chk4(o1, 4'h0);
    chk4(e1 | e2, 4'h0);
    chk4(rdData, 4'h0);
    chk1(testFlag | haltRelease, 1'b0);
    rst = 1'b0;
    @(posedge clk_sys);
    #1;
    chk4(e1 & e2, 4'hF);
    $display("test_reset done");
  endtask : test_reset

  // print counts and the verdict, then stop
  task automatic report_and_stop;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk4(hv[0], 4'h0);
    test_inputs();
    test_bidir();
    test_hv();
    test_narrow();
    test_halt();
    test_reset();
    report_and_stop();
  end
endmodule : test_display_driver_io_ports
